// ==== rtl/reset_irq_vector_placement.sv ====
// Reset and interrupt vector placement: picks the fetch address for reset and dispatch.
// Assumes request and enable lines are synchronous to i_clk; the fuse is a static strap.
`timescale 1ns/1ns
`default_nettype none
module reset_irq_vector_placement
  import vector_place_pkg::*;
#(
  parameter bit               ONE_WORD_VECTORS = 1'b0,
  parameter logic [12:0]      BOOT_RESET_ADDR  = BOOT_RESET_WIDE
) (
  // Clock and reset.
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst,
  // Configuration.
  input  wire logic                                  i_boot_reset_fuse,
  input  wire logic                                  i_vector_select_bit,
  // Interrupt sources, bit n is vector n+1 in the table.
  input  wire logic [vector_place_pkg::NUM_IRQ-1:0]  i_irq_request,
  input  wire logic [vector_place_pkg::NUM_IRQ-1:0]  i_irq_enable,
  // Core handshake.
  input  wire logic                                  i_global_irq_enable,
  input  wire logic                                  i_core_ready,
  // Fetch address toward the program counter.
  output logic      [vector_place_pkg::PC_WIDTH-1:0] o_fetch_addr,
  output logic                                       o_fetch_load,
  output logic                                       o_irq_ack_valid,
  output logic      [vector_place_pkg::IRQ_IDX_WIDTH-1:0] o_irq_ack_index,
  output logic                                       o_reset_fetch
);
  import vector_place_pkg::*;

  // Two-word vectors need an even boot base, or every slot would straddle a pair.
  if (BOOT_RESET_ADDR[0] != 1'b0 && !ONE_WORD_VECTORS) begin : g_bad_boot_addr
    $error("Boot reset address must be even for two-word vectors.");
  end

  typedef enum logic [3:0] {
    ST_RESET  = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_IDLE   = 4'b0100,
    ST_WAIT   = 4'b1000
  } state_e;

  state_e                   state;
  state_e                   next_state;
  logic                     fuse_sync1;
  logic                     fuse_sync2;
  logic                     sel_sync1;
  logic                     sel_sync2;
  logic [NUM_IRQ-1:0]       pending;
  logic                     any_pending;
  logic [IRQ_IDX_WIDTH-1:0] win_index;
  logic [PC_WIDTH-1:0]      reset_addr;
  logic [PC_WIDTH-1:0]      vec_base;
  logic [PC_WIDTH-1:0]      vec_stride;
  logic [PC_WIDTH-1:0]      vec_addr;

  // The fuse and select bit are treated as slow levels and synchronised before use.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fuse_sync1 <= 1'b1;
      fuse_sync2 <= 1'b1;
      sel_sync1  <= 1'b0;
      sel_sync2  <= 1'b0;
    end else begin
      fuse_sync1 <= i_boot_reset_fuse;
      fuse_sync2 <= fuse_sync1;
      sel_sync1  <= i_vector_select_bit;
      sel_sync2  <= sel_sync1;
    end
  end

  // Only enabled and requesting sources count; slots nobody asks for are never fetched.
  always_comb begin
    pending     = i_irq_request & i_irq_enable;
    any_pending = (|pending) && i_global_irq_enable;
  end

  // Priority search from the top down so the lowest index is written last and wins.
  always_comb begin
    win_index = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_index = IRQ_IDX_WIDTH'(i);
      end
    end
  end

  // Reset address depends on the fuse alone; vector base on the select bit alone.
  always_comb begin
    if (fuse_sync2 == FUSE_PROGRAMMED) begin
      reset_addr = BOOT_RESET_ADDR;
    end else begin
      reset_addr = RESET_ADDR_APP;
    end
    if (sel_sync2) begin
      vec_base = BOOT_RESET_ADDR;
    end else begin
      vec_base = APP_VEC_BASE;
    end
    if (ONE_WORD_VECTORS) begin
      vec_stride = NARROW_STRIDE;
    end else begin
      vec_stride = WIDE_STRIDE;
    end
  end

  // Table slot arithmetic: slot n+1 times stride, added to base.
  vector_addr_calc #(
    .W (PC_WIDTH)
  ) u_calc (
    .i_base   (vec_base),
    .i_stride (vec_stride),
    .i_index  (win_index),
    .o_addr   (vec_addr)
  );

  // The reset fetch waits until the fuse has passed both synchroniser stages after release;
  // the second stage only carries the real strap from the second edge onward.
  always_comb begin
    case (state)
      ST_RESET:  next_state = ST_SETTLE;
      ST_SETTLE: next_state = ST_WAIT;
      ST_WAIT:  next_state = ST_IDLE;
      ST_IDLE:  next_state = ST_IDLE;
      default:  next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Fetch outputs: one-cycle load pulse with the address held until the next load.
  // Waiting two cycles after release lets the fuse synchroniser fill before the reset fetch.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch_addr    <= RESET_ADDR_APP;
      o_fetch_load    <= 1'b0;
      o_irq_ack_valid <= 1'b0;
      o_irq_ack_index <= '0;
      o_reset_fetch   <= 1'b0;
    end else begin
      o_fetch_load    <= 1'b0;
      o_irq_ack_valid <= 1'b0;
      o_reset_fetch   <= 1'b0;
      if (state == ST_WAIT) begin
        o_fetch_addr  <= reset_addr;
        o_fetch_load  <= 1'b1;
        o_reset_fetch <= 1'b1;
      end else if (state == ST_IDLE && i_core_ready && any_pending && !o_fetch_load) begin
        o_fetch_addr    <= vec_addr;
        o_fetch_load    <= 1'b1;
        o_irq_ack_valid <= 1'b1;
        o_irq_ack_index <= win_index;
      end
    end
  end
endmodule : reset_irq_vector_placement
`default_nettype wire

// ==== rtl/vector_addr_calc.sv ====
// Address arithmetic for one vector: base plus stride times slot.
// Assumes purely combinational use from the selector in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module vector_addr_calc
  import vector_place_pkg::*;
#(
  parameter int unsigned W = PC_WIDTH
) (
  // Operands.
  input  wire logic [W-1:0]             i_base,
  input  wire logic [W-1:0]             i_stride,
  input  wire logic [IRQ_IDX_WIDTH-1:0] i_index,
  // Result.
  output logic      [W-1:0]             o_addr
);
  logic [W-1:0] slot;

  // Slot zero is reset, so interrupt index n occupies slot n+1.
  always_comb begin
    slot   = W'(i_index) + W'(1);
    o_addr = W'(i_base + W'(i_stride * slot));
  end
endmodule : vector_addr_calc
`default_nettype wire

// ==== rtl/vector_place_pkg.sv ====
// Constants for the reset and interrupt vector placement block.
// Assumes a word-addressed program counter of PC_WIDTH bits.
package vector_place_pkg;
  localparam int unsigned PC_WIDTH        = 13;
  localparam int unsigned NUM_IRQ         = 25;
  localparam int unsigned IRQ_IDX_WIDTH   = 5;
  // Reset address when the boot-reset fuse is unprogrammed.
  localparam logic [12:0] RESET_ADDR_APP  = 13'h0000;
  // Application table base; vector n (n=0 is the first interrupt) sits at base + stride*(n+1).
  localparam logic [12:0] APP_VEC_BASE    = 13'h0000;
  // Wide-vector part: two words apart.
  localparam logic [12:0] WIDE_STRIDE     = 13'h0002;
  // One-word-vector part: one word apart.
  localparam logic [12:0] NARROW_STRIDE   = 13'h0001;
  // Default boot reset address for a 2K-byte boot section on the wide part.
  localparam logic [12:0] BOOT_RESET_WIDE = 13'h1C00;
  // Boot reset address for the one-word-vector part with a 2K-byte boot section.
  localparam logic [12:0] BOOT_RESET_NARROW = 13'h0C00;
  // Fuse encoding: 1 is unprogrammed, 0 is programmed.
  localparam logic        FUSE_PROGRAMMED = 1'b0;
endpackage : vector_place_pkg

// ==== testbench/core_model.sv ====
// Core model: takes each fetch load, and when slow stays busy a while.
// Assumes i_fetch_load is the block's one-cycle load pulse.
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  input  wire logic i_fetch_load,
  output logic      o_core_ready
);
  logic [1:0] busy;
  // A slow core needs three cycles to redirect, so dispatch must wait on ready.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) busy <= 2'h0;
    else if (i_fetch_load && i_slow) busy <= 2'h3;
    else if (busy != 2'h0) busy <= busy - 2'h1;
  end
  assign o_core_ready = (busy == 2'h0);
endmodule : core_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Bench: reset placement, every source, random priority and masking.
// Assumes the default wide part with the package boot address.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vector_place_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, fuse = 1'b1, vsel = 1'b0, glb = 1'b0, slow = 1'b0;
  logic ready, load, ackv, rfetch;
  logic [24:0] req = '0, en = '0;
  logic [12:0] addr;
  logic [4:0] idx;
  logic [31:0] seed = 32'h08A1;
  integer mismatches = 0, checks = 0, cycles = 0, f, n;
  reset_irq_vector_placement i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_boot_reset_fuse(fuse),
    .i_vector_select_bit(vsel), .i_irq_request(req), .i_irq_enable(en),
    .i_global_irq_enable(glb), .i_core_ready(ready), .o_fetch_addr(addr),
    .o_fetch_load(load), .o_irq_ack_valid(ackv), .o_irq_ack_index(idx), .o_reset_fetch(rfetch));
  core_model i_core (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_fetch_load(load),
    .o_core_ready(ready));
  initial forever #50 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // Outputs are looked at on falling edges, where registered values have settled.
  task automatic wait_load();
    integer k;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (load !== 1'b1 && k < 12);
  endtask : wait_load
  task automatic do_reset(input logic fz, input logic vs);
    @(posedge i_clk);
    i_rst <= 1'b1;
    fuse <= fz;
    vsel <= vs;
    slow <= vs;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    wait_load();
    check(rfetch, 1'b1, "reset_fetch");
    check(addr, fz ? RESET_ADDR_APP : BOOT_RESET_WIDE, "reset_addr");
  endtask : do_reset
  // Requests are dropped at the edge after the ack, as the requester must.
  task automatic dispatch(input logic [24:0] rq, input logic [24:0] ro, input logic g);
    integer k;
    logic [24:0] p;
    logic [31:0] e;
    p = rq & ro & {25{g}};
    k = 0;
    while (k < 24 && !p[k]) k++;
    e = (vsel ? BOOT_RESET_WIDE : APP_VEC_BASE) + WIDE_STRIDE * (k + 1);
    @(posedge i_clk);
    req <= rq;
    en <= ro;
    glb <= g;
    wait_load();
    check({load, ackv}, p != '0 ? 2'h3 : 2'h0, "load_ack");
    if (p != '0) begin
      check(idx, k, "ack_index");
      check(addr, e, "vec_addr");
    end
    @(posedge i_clk);
    req <= '0;
    repeat (2) @(posedge i_clk);
  endtask : dispatch
  initial begin
    for (f = 0; f < 4; f++) begin
      do_reset(f[1], f[0]);
      for (n = 0; n < 25; n++) dispatch(25'h1 << n, 25'h1 << n, 1'b1);
      for (n = 0; n < 6; n++) begin
        seed = lfsr(seed);
        dispatch(seed[24:0], lfsr(seed) >> 3, n != 5);
      end
    end
    final_report();
  end
  // A hang past the expected run length counts as a mismatch.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
endmodule : testbench
`default_nettype wire

// ==== testbench/vector_place_sva.sv ====
// Checker on the placement block's ports, bound at the foot of this file.
// Assumes straps change only in reset or while no request is pending.
`timescale 1ns/1ns
`default_nettype none
module vector_place_sva
  import vector_place_pkg::*;
#(
  parameter bit          ONE_WORD_VECTORS = 1'b0,
  parameter logic [12:0] BOOT_RESET_ADDR  = BOOT_RESET_WIDE
) (
  input wire logic [0:0]  i_clk, i_rst, i_boot_reset_fuse, i_vector_select_bit,
  input wire logic [24:0] i_irq_request, i_irq_enable,
  input wire logic [0:0]  i_global_irq_enable, i_core_ready,
  input wire logic [12:0] o_fetch_addr,
  input wire logic [0:0]  o_fetch_load, o_irq_ack_valid, o_reset_fetch,
  input wire logic [4:0]  o_irq_ack_index
);
  logic [24:0] taken;
  logic [12:0] stride;
  // Pending set one edge back, since the answer lags the request by one cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) taken <= '0;
    else taken <= i_irq_request & i_irq_enable & {25{i_global_irq_enable & i_core_ready}};
  end
  assign stride = ONE_WORD_VECTORS ? NARROW_STRIDE : WIDE_STRIDE;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  load_gap_a: assert property (o_fetch_load |=> !o_fetch_load)
    else $error("adjacent fetch loads");
  ack_load_a: assert property (o_irq_ack_valid |-> o_fetch_load && !o_reset_fetch)
    else $error("ack without load");
  rst_load_a: assert property (o_reset_fetch |-> o_fetch_load && !o_irq_ack_valid)
    else $error("reset fetch without load");
  rst_addr_a: assert property (o_reset_fetch |->
    o_fetch_addr == (i_boot_reset_fuse ? RESET_ADDR_APP : BOOT_RESET_ADDR))
    else $error("wrong reset address");
  vec_addr_a: assert property (o_irq_ack_valid |-> o_fetch_addr ==
    (i_vector_select_bit ? BOOT_RESET_ADDR : APP_VEC_BASE) + stride * (o_irq_ack_index + 13'h1))
    else $error("wrong vector address");
  src_live_a: assert property (o_irq_ack_valid |-> taken[o_irq_ack_index])
    else $error("dispatch of an idle source");
  lowest_src_a: assert property (o_irq_ack_valid |->
    (taken & ((25'h1 << o_irq_ack_index) - 25'h1)) == '0) else $error("lower source skipped");
  boot_fetch_a: assert property ($fell(i_rst) |-> ##[1:4] o_reset_fetch)
    else $error("no reset fetch after release");
  c_boot_vec: cover property (o_irq_ack_valid && i_vector_select_bit);
  c_boot_rst: cover property (o_reset_fetch && !i_boot_reset_fuse);
  c_last_src: cover property (o_irq_ack_valid && o_irq_ack_index == 5'h18);
endmodule : vector_place_sva
bind reset_irq_vector_placement vector_place_sva #(
  .ONE_WORD_VECTORS(ONE_WORD_VECTORS), .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) i_sva (.*);
`default_nettype wire
